// [inc/gauge_pkg.sv]
package gauge_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG_A      = 8'h00;
  localparam logic [7:0] OFS_CFG_B      = 8'h04;
  localparam logic [7:0] OFS_DEBUG      = 8'h08;
  localparam logic [7:0] OFS_LOW_CAPACITY_FLAG_SET   = 8'h0c;
  localparam logic [7:0] OFS_LOW_CAPACITY_FLAG_CLR   = 8'h10;
  localparam logic [7:0] OFS_SD_SET_V   = 8'h14;
  localparam logic [7:0] OFS_SD_CLR_V   = 8'h18;
  localparam logic [7:0] OFS_SD_TIME    = 8'h1c;
  localparam logic [7:0] OFS_FINAL_V    = 8'h20;
  localparam logic [7:0] OFS_SLEEP_I    = 8'h24;
  localparam logic [7:0] OFS_BUS_TMO    = 8'h28;
  localparam logic [7:0] OFS_WR_WAIT    = 8'h2c;
  localparam logic [7:0] OFS_HOST_TEMP  = 8'h30;
  localparam logic [7:0] OFS_CMD        = 8'h34;
  localparam logic [7:0] OFS_STATUS     = 8'h38;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CFG_A     = 16'h0933;
  localparam logic [7:0]  RST_CFG_B     = 8'h53;
  localparam logic [7:0]  RST_DEBUG     = 8'h00;
  localparam logic [15:0] RST_LOW_CAPACITY_FLAG_SET  = 16'h0096;
  localparam logic [15:0] RST_LOW_CAPACITY_FLAG_CLR  = 16'h00af;
  localparam logic [15:0] RST_SD_SET_V  = 16'h0c4e;
  localparam logic [15:0] RST_SD_CLR_V  = 16'h0d48;
  localparam logic [15:0] RST_SD_TIME   = 16'h0002;
  localparam logic [15:0] RST_FINAL_V   = 16'h0bb8;
  localparam logic [15:0] RST_SLEEP_I   = 16'h000a;
  localparam logic [2:0]  RST_BUS_TMO   = 3'h4;
  localparam logic [7:0]  RST_WR_WAIT   = 8'h00;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int BIT_GOOD_OVR     = 14;
  localparam int BIT_REMOVAL_IRQ  = 13;
  localparam int BIT_PFC_HI       = 12;
  localparam int BIT_PFC_LO       = 11;
  localparam int BIT_WAKE_RANGE   = 10;
  localparam int BIT_SENSE_HI     = 9;
  localparam int BIT_SENSE_LO     = 8;
  localparam int BIT_INIT_OCV     = 7;
  localparam int BIT_SLEEP_EN     = 5;
  localparam int BIT_CAP_LOAD     = 4;
  localparam int BIT_IRQ_POL      = 3;
  localparam int BIT_GOOD_POL     = 2;
  localparam int BIT_LOW_POL      = 1;
  localparam int BIT_TEMP_SRC     = 0;
  localparam int BIT_TEMP_WR      = 7;
  localparam int BIT_INS_DET      = 6;
  localparam int BIT_WR_IND_SEL   = 2;
  localparam int BIT_DELTA_HI     = 1;
  localparam int BIT_DELTA_LO     = 0;
  localparam int BIT_CMD_DETECT   = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int PULSE_US         = 1000;
  localparam int PULSE_CYC        = PULSE_US * CLK_MHZ;
  localparam int WAIT_UNIT_US     = 5;
  localparam int WAIT_UNIT_CYC    = WAIT_UNIT_US * CLK_MHZ;
  localparam int TMO_STEP_MS      = 500;
  localparam int TMO_STEP_CYC     = TMO_STEP_MS * 1000 * CLK_MHZ;
  localparam int SD_TICK_MS       = 1000;
  localparam int SD_TICK_CYC      = SD_TICK_MS * 1000 * CLK_MHZ;

  // wake thresholds in units of 1.25 mV, indexed {sense_hi, sense_lo, range}
  localparam logic [3:0] WAKE_TH [8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8};

  typedef enum logic [1:0] {PFC_MODE0, PFC_MODE1, PFC_MODE2, PFC_BAD} pfc_e;
  typedef enum logic [1:0] {DV_STANDARD, DV_NO_AVG, DV_MIN_DELTA, DV_UNUSED} delta_e;

endpackage

// [rtl/discharge_alarm.sv]
`timescale 1ns/1ps
// Operation
// - set low-capacity flag when remaining capacity falls below set threshold
// - clear low-capacity flag when capacity reaches clear threshold or more
// - low-battery pin follows the low-capacity flag
// - set shutdown warning after voltage below threshold for set time; interrupt
// - clear shutdown warning when voltage rises above clear threshold
// - pulse interrupt output 1 ms on battery removal when enabled
// - decode pin-function bits 00/01/10 into modes 0/1/2
// - wake threshold from sense bits and range bit; 00 disables
// - in sleep or hibernate raise wake when current beyond threshold
// - pulse interrupt during first open-circuit measurement when enabled
// - allow sleep only when enabled and average current at most sleep current
// - load remaining capacity with full capacity on termination when enabled
// - output polarities set by polarity bits
// - temperature from external sensor when select is 1, else internal
// - bus timeout off at 0, else setting times half a second
// - write indication on interrupt pin or low-battery pin by select bit
// - accept host-written temperature when enabled
// - without insertion detect, host command sets battery-detected bit
// - keep battery-good asserted in voltage-only hibernate when override set
// - decode delta-voltage method from two bits
module discharge_alarm
  import gauge_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int TMO_CYCLES   = TMO_STEP_CYC,
  parameter int TICK_CYCLES  = SD_TICK_CYC,
  parameter int UNIT_CYCLES  = WAIT_UNIT_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // measurements
  input  wire logic        meas_valid,
  input  wire logic [15:0] remaining_cap,
  input  wire logic [15:0] full_cap,
  input  wire logic [15:0] cell_voltage,
  input  wire logic [15:0] avg_current,
  input  wire logic [15:0] sense_mag,
  input  wire logic [15:0] temp_external,
  input  wire logic [15:0] temp_internal,
  // gauge events
  input  wire logic        low_power_state,
  input  wire logic        hibernate_by_voltage,
  input  wire logic        battery_removed,
  input  wire logic        first_ocv,
  input  wire logic        charge_terminated,
  input  wire logic        insertion_seen,
  input  wire logic        flash_write_req,
  input  wire logic        bus_activity,
  input  wire logic        battery_good_raw,
  // outputs
  output logic             soc_irq_pin,
  output logic             low_battery_pin,
  output logic             battery_good_pin,
  output logic             wake_irq,
  output logic             sleep_allow,
  output logic             cap_load,
  output logic             soc_zero,
  output logic             flash_write_go,
  output logic             bus_timeout,
  output logic [15:0]      temperature,
  output logic [1:0]       pin_mode,
  output logic [1:0]       delta_mode
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_a_reg;
  logic [7:0]  cfg_b_reg;
  logic [7:0]  debug_reg;
  logic [15:0] low_capacity_flag_set_reg;
  logic [15:0] low_capacity_flag_clr_reg;
  logic [15:0] sd_set_reg;
  logic [15:0] sd_clr_reg;
  logic [15:0] sd_time_reg;
  logic [15:0] final_v_reg;
  logic [15:0] sleep_i_reg;
  logic [2:0]  tmo_reg;
  logic [7:0]  wr_wait_reg;
  logic [15:0] host_temp_reg;
  logic        detected_reg;
  logic        low_cap_flag;
  logic        shutdown_warning_flag;
  logic        wr_act;
  logic        wr_cmd;
  logic        rd_act;
  logic        detect_cmd;
  logic        mapped;
  logic [31:0] rd_next;

  assign wr_act = clk_en && psel && penable && pwrite && pready;
  assign rd_act = clk_en && psel && penable && !pwrite && pready;
  assign wr_cmd = wr_act && (paddr == OFS_CMD);
  assign detect_cmd = wr_cmd && pwdata[BIT_CMD_DETECT];

  always_comb begin
    mapped  = 1'b1;
    rd_next = 32'h0;
    unique case (paddr)
      OFS_CFG_A:     rd_next = {16'h0, cfg_a_reg};
      OFS_CFG_B:     rd_next = {24'h0, cfg_b_reg};
      OFS_DEBUG:     rd_next = {24'h0, debug_reg};
      OFS_LOW_CAPACITY_FLAG_SET:  rd_next = {16'h0, low_capacity_flag_set_reg};
      OFS_LOW_CAPACITY_FLAG_CLR:  rd_next = {16'h0, low_capacity_flag_clr_reg};
      OFS_SD_SET_V:  rd_next = {16'h0, sd_set_reg};
      OFS_SD_CLR_V:  rd_next = {16'h0, sd_clr_reg};
      OFS_SD_TIME:   rd_next = {16'h0, sd_time_reg};
      OFS_FINAL_V:   rd_next = {16'h0, final_v_reg};
      OFS_SLEEP_I:   rd_next = {16'h0, sleep_i_reg};
      OFS_BUS_TMO:   rd_next = {29'h0, tmo_reg};
      OFS_WR_WAIT:   rd_next = {24'h0, wr_wait_reg};
      OFS_HOST_TEMP: rd_next = {16'h0, host_temp_reg};
      OFS_CMD:       rd_next = 32'h0;
      OFS_STATUS:    rd_next = {29'h0, detected_reg, shutdown_warning_flag, low_cap_flag};
      default:       mapped  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb handshake: one wait state, ready in the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_reg     <= RST_CFG_A;
      cfg_b_reg     <= RST_CFG_B;
      debug_reg     <= RST_DEBUG;
      low_capacity_flag_set_reg  <= RST_LOW_CAPACITY_FLAG_SET;
      low_capacity_flag_clr_reg  <= RST_LOW_CAPACITY_FLAG_CLR;
      sd_set_reg    <= RST_SD_SET_V;
      sd_clr_reg    <= RST_SD_CLR_V;
      sd_time_reg   <= RST_SD_TIME;
      final_v_reg   <= RST_FINAL_V;
      sleep_i_reg   <= RST_SLEEP_I;
      tmo_reg       <= RST_BUS_TMO;
      wr_wait_reg   <= RST_WR_WAIT;
      host_temp_reg <= 16'h0;
    end else if (wr_act) begin
      unique case (paddr)
        OFS_CFG_A:     cfg_a_reg    <= pwdata[15:0];
        OFS_CFG_B:     cfg_b_reg    <= pwdata[7:0];
        OFS_DEBUG:     debug_reg    <= {5'h0, pwdata[2:0]};
        OFS_LOW_CAPACITY_FLAG_SET:  low_capacity_flag_set_reg <= pwdata[15:0];
        OFS_LOW_CAPACITY_FLAG_CLR:  low_capacity_flag_clr_reg <= pwdata[15:0];
        OFS_SD_SET_V:  sd_set_reg   <= pwdata[15:0];
        OFS_SD_CLR_V:  sd_clr_reg   <= pwdata[15:0];
        OFS_SD_TIME:   sd_time_reg  <= pwdata[15:0];
        OFS_FINAL_V:   final_v_reg  <= pwdata[15:0];
        OFS_SLEEP_I:   sleep_i_reg  <= pwdata[15:0];
        OFS_BUS_TMO:   tmo_reg      <= pwdata[2:0];
        OFS_WR_WAIT:   wr_wait_reg  <= pwdata[7:0];
        OFS_HOST_TEMP: begin
          if (cfg_b_reg[BIT_TEMP_WR]) begin
            host_temp_reg <= pwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // battery detected: hardware detection or host command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detected_reg <= 1'b0;
    end else if (clk_en) begin
      if ((cfg_b_reg[BIT_INS_DET] && insertion_seen) || detect_cmd) begin
        detected_reg <= 1'b1;
      end else if (battery_removed) begin
        detected_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // discharge alarms
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic [15:0] sd_sec;
  logic        sd_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cap_flag <= 1'b0;
    end else if (clk_en && meas_valid) begin
      if (remaining_cap < low_capacity_flag_set_reg) begin
        low_cap_flag <= 1'b1;
      end else if (remaining_cap >= low_capacity_flag_clr_reg) begin
        low_cap_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0;
      sd_sec   <= 16'h0;
    end else if (clk_en) begin
      if (meas_valid && cell_voltage >= sd_set_reg) begin
        tick_cnt <= 32'h0;
        sd_sec   <= 16'h0;
      end else if (cell_voltage < sd_set_reg && sd_sec < sd_time_reg) begin
        if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
          tick_cnt <= 32'h0;
          sd_sec   <= sd_sec + 16'h1;
        end else begin
          tick_cnt <= tick_cnt + 32'h1;
        end
      end
    end
  end

  assign sd_fire = meas_valid && cell_voltage < sd_set_reg && sd_sec >= sd_time_reg
                   && !shutdown_warning_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_warning_flag <= 1'b0;
    end else if (clk_en) begin
      if (sd_fire) begin
        shutdown_warning_flag <= 1'b1;
      end else if (meas_valid && shutdown_warning_flag && cell_voltage > sd_clr_reg) begin
        shutdown_warning_flag <= 1'b0;
      end
    end
  end

  chk_shutdown_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sd_fire |=> shutdown_warning_flag)
    else $error("shutdown warning not set after duration");

  chk_low_cap_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && meas_valid && remaining_cap < low_capacity_flag_set_reg |=> low_cap_flag)
    else $error("low capacity flag not set");

  chk_low_cap_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && meas_valid && remaining_cap >= low_capacity_flag_clr_reg
    && remaining_cap >= low_capacity_flag_set_reg |=> !low_cap_flag)
    else $error("low capacity flag not cleared");

  // ----------------------------------------------------------------
  // interrupt pulse and flash write indication
  // ----------------------------------------------------------------
  logic [31:0] pulse_cnt;
  logic        pulse_on;
  logic [15:0] wait_cnt;
  logic [31:0] unit_cnt;
  logic        wr_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= 32'h0;
    end else if (clk_en) begin
      if ((battery_removed && cfg_a_reg[BIT_REMOVAL_IRQ]) || sd_fire) begin
        pulse_cnt <= 32'(PULSE_CYCLES);
      end else if (first_ocv && cfg_a_reg[BIT_INIT_OCV]) begin
        pulse_cnt <= 32'(PULSE_CYCLES);
      end else if (pulse_cnt != 32'h0) begin
        pulse_cnt <= pulse_cnt - 32'h1;
      end
    end
  end
  assign pulse_on = pulse_cnt != 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_busy        <= 1'b0;
      wait_cnt       <= 16'h0;
      unit_cnt       <= 32'h0;
      flash_write_go <= 1'b0;
    end else if (clk_en) begin
      flash_write_go <= 1'b0;
      if (!wr_busy && flash_write_req) begin
        wr_busy  <= 1'b1;
        wait_cnt <= {8'h0, wr_wait_reg};
        unit_cnt <= 32'h0;
      end else if (wr_busy) begin
        if (wait_cnt == 16'h0) begin
          wr_busy        <= 1'b0;
          flash_write_go <= 1'b1;
        end else if (unit_cnt == 32'(UNIT_CYCLES - 1)) begin
          unit_cnt <= 32'h0;
          wait_cnt <= wait_cnt - 16'h1;
        end else begin
          unit_cnt <= unit_cnt + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and decoded configuration
  // ----------------------------------------------------------------
  logic        irq_active;
  logic        low_active;
  logic        good_active;
  logic [15:0] wake_th;
  logic [2:0]  tmo_set;
  logic [31:0] tmo_cnt;
  logic [2:0]  tmo_steps;

  assign wake_th = {12'h0, WAKE_TH[{cfg_a_reg[BIT_SENSE_HI], cfg_a_reg[BIT_SENSE_LO],
                                    cfg_a_reg[BIT_WAKE_RANGE]}]};
  assign irq_active  = pulse_on || (wr_busy && !cfg_b_reg[BIT_WR_IND_SEL]);
  assign low_active  = low_cap_flag || (wr_busy && cfg_b_reg[BIT_WR_IND_SEL]);
  assign good_active = battery_good_raw
                       || (hibernate_by_voltage && cfg_a_reg[BIT_GOOD_OVR]);
  assign tmo_set = tmo_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soc_irq_pin      <= 1'b1;
      low_battery_pin  <= 1'b0;
      battery_good_pin <= 1'b1;
      wake_irq         <= 1'b0;
      sleep_allow      <= 1'b0;
      cap_load         <= 1'b0;
      soc_zero         <= 1'b0;
      temperature      <= 16'h0;
      pin_mode         <= 2'h1;
      delta_mode       <= 2'h0;
    end else if (clk_en) begin
      soc_irq_pin      <= irq_active ^ !cfg_a_reg[BIT_IRQ_POL];
      low_battery_pin  <= low_active ^ !cfg_a_reg[BIT_LOW_POL];
      battery_good_pin <= good_active ^ !cfg_a_reg[BIT_GOOD_POL];
      wake_irq         <= low_power_state && wake_th != 16'h0 && sense_mag > wake_th;
      sleep_allow      <= cfg_a_reg[BIT_SLEEP_EN] && avg_current <= sleep_i_reg;
      cap_load         <= charge_terminated && cfg_a_reg[BIT_CAP_LOAD];
      if (meas_valid) begin
        soc_zero <= cell_voltage <= final_v_reg;
      end
      if (cfg_b_reg[BIT_TEMP_WR]) begin
        temperature <= host_temp_reg;
      end else begin
        temperature <= cfg_a_reg[BIT_TEMP_SRC] ? temp_external : temp_internal;
      end
      pin_mode   <= {cfg_a_reg[BIT_PFC_HI], cfg_a_reg[BIT_PFC_LO]};
      delta_mode <= {debug_reg[BIT_DELTA_HI], debug_reg[BIT_DELTA_LO]};
    end
  end

  // bus timeout: time with bus_activity high counted in half-second steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt     <= 32'h0;
      tmo_steps   <= 3'h0;
      bus_timeout <= 1'b0;
    end else if (clk_en) begin
      bus_timeout <= 1'b0;
      if (tmo_set == 3'h0 || !bus_activity) begin
        tmo_cnt   <= 32'h0;
        tmo_steps <= 3'h0;
      end else if (tmo_cnt == 32'(TMO_CYCLES - 1)) begin
        tmo_cnt <= 32'h0;
        if (tmo_steps == tmo_set - 3'h1) begin
          bus_timeout <= 1'b1;
          tmo_steps   <= 3'h0;
        end else begin
          tmo_steps <= tmo_steps + 3'h1;
        end
      end else begin
        tmo_cnt <= tmo_cnt + 32'h1;
      end
    end
  end

  chk_low_pin_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !wr_busy |=> low_battery_pin == ($past(low_cap_flag) ^ !$past(cfg_a_reg[1])))
    else $error("low battery pin does not follow flag");

  chk_removal_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && battery_removed && cfg_a_reg[13] |=> pulse_cnt == 32'(PULSE_CYCLES))
    else $error("removal pulse not started");

  chk_sleep_gate: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_allow |-> $past(cfg_a_reg[5]) || !$past(clk_en))
    else $error("sleep allowed while disabled");

  chk_temp_source: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !cfg_b_reg[7] && cfg_a_reg[0] |=> temperature == $past(temp_external))
    else $error("temperature not from external sensor");

  chk_write_delay: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !wr_busy && flash_write_req && wr_wait_reg != 8'h0 |=> !flash_write_go[*2])
    else $error("flash write started without delay");

  chk_pin_mode: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> pin_mode == $past(cfg_a_reg[12:11]))
    else $error("pin mode decode wrong");

endmodule

// [testbench/host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host view of the alarm pins
// ------------------------------------------------------------
module host_model (
  // pins
  input  wire logic        soc_irq_pin,
  input  wire logic        low_battery_pin,
  input  wire logic        battery_good_pin,
  // configuration the host wrote
  input  wire logic [15:0] cfg_a,
  // logical states
  output logic             irq_act,
  output logic             low_act,
  output logic             good_act
);
  assign irq_act  = soc_irq_pin ^ !cfg_a[3];
  assign good_act = battery_good_pin ^ !cfg_a[2];
  assign low_act  = low_battery_pin ^ !cfg_a[1];
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import gauge_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        meas_valid, low_power_state, hibernate_by_voltage, battery_removed, first_ocv;
  logic        charge_terminated, insertion_seen, flash_write_req, bus_activity;
  logic        battery_good_raw, soc_irq_pin, low_battery_pin, battery_good_pin, wake_irq;
  logic        sleep_allow, cap_load, soc_zero, flash_write_go, bus_timeout;
  logic        irq_act, low_act, good_act;
  logic [15:0] remaining_cap, full_cap, cell_voltage, avg_current, sense_mag;
  logic [15:0] temp_external, temp_internal, temperature, cfg_a;
  logic [1:0]  pin_mode, delta_mode;
  int          num_errors, compares;

  discharge_alarm #(.PULSE_CYCLES(8), .TMO_CYCLES(8), .TICK_CYCLES(4), .UNIT_CYCLES(2))
  discharge_alarm_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .meas_valid, .remaining_cap, .full_cap, .cell_voltage,
    .avg_current, .sense_mag, .temp_external, .temp_internal, .low_power_state,
    .hibernate_by_voltage, .battery_removed, .first_ocv, .charge_terminated, .insertion_seen,
    .flash_write_req, .bus_activity, .battery_good_raw, .soc_irq_pin, .low_battery_pin,
    .battery_good_pin, .wake_irq, .sleep_allow, .cap_load, .soc_zero, .flash_write_go,
    .bus_timeout, .temperature, .pin_mode, .delta_mode);

  host_model host_model_inst (.soc_irq_pin, .low_battery_pin, .battery_good_pin, .cfg_a,
    .irq_act, .low_act, .good_act);

  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      results();
    end else begin
      rdat = prdata; rerr = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(0, a, 32'h0);
    chk(n, x, rdat);
  endtask

  task automatic meas(input logic [15:0] c, input logic [15:0] v);
    @(posedge pclk);
    remaining_cap <= c; cell_voltage <= v; meas_valid <= 1;
    @(posedge pclk);
    meas_valid <= 0;
    repeat (3) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    int k;
    num_errors = 0; compares = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0;
    pwrite = 0; paddr = 8'h00; pwdata = 32'h0; meas_valid = 0; low_power_state = 0;
    hibernate_by_voltage = 0; battery_removed = 0; first_ocv = 0; charge_terminated = 0;
    insertion_seen = 0; flash_write_req = 0; bus_activity = 0; battery_good_raw = 1;
    remaining_cap = 16'h00c8; full_cap = 16'h03e8; cell_voltage = 16'h0e10;
    avg_current = 16'h0005; sense_mag = 16'h0000; temp_external = 16'h1111;
    temp_internal = 16'h2222; cfg_a = RST_CFG_A;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(OFS_CFG_A, {16'h0, RST_CFG_A}, "cfg_a");
    rd(OFS_CFG_B, {24'h0, RST_CFG_B}, "cfg_b");
    apb(0, 8'h3c, 32'h0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rdat);
    @(posedge pclk) insertion_seen <= 1;
    @(posedge pclk) insertion_seen <= 0;
    meas(16'h00c8, 16'h0e10);
    rd(OFS_STATUS, 32'h4, "status");
    chk("sleep", 1, sleep_allow);
    chk("good act", 1, good_act);
    @(posedge pclk) begin
      low_power_state   <= 1;
      sense_mag         <= 16'h0002;
      charge_terminated <= 1;
    end
    repeat (2) @(posedge pclk);
    chk("wake", 1, wake_irq);
    chk("cap load", 1, cap_load);
    meas(16'h0095, 16'h0e10);
    rd(OFS_STATUS, 32'h5, "status");
    chk("low act", 1, low_act);
    chk("low pin", 1, low_battery_pin);
    cfg_a = 16'h0931;
    wr(OFS_CFG_A, 32'h0931);
    repeat (2) @(posedge pclk);
    chk("low pin", 0, low_battery_pin);
    meas(16'h00ae, 16'h0e10);
    rd(OFS_STATUS, 32'h5, "status");
    meas(16'h00af, 16'h0e10);
    rd(OFS_STATUS, 32'h4, "status");
    chk("low act", 0, low_act);
    meas(16'h00c8, 16'h0c1c);
    rd(OFS_STATUS, 32'h4, "status");
    repeat (12) @(posedge pclk);
    meas(16'h00c8, 16'h0c1c);
    chk("irq act", 1, irq_act);
    rd(OFS_STATUS, 32'h6, "status");
    meas(16'h00c8, 16'h0ce4);
    rd(OFS_STATUS, 32'h6, "status");
    meas(16'h00c8, 16'h0d49);
    rd(OFS_STATUS, 32'h4, "status");
    meas(16'h00c8, 16'h0bb8);
    chk("soc zero", 1, soc_zero);
    chk("temp", 32'h1111, temperature);
    cfg_a = 16'h2932;
    wr(OFS_CFG_A, 32'h2932);
    repeat (2) @(posedge pclk);
    chk("temp", 32'h2222, temperature);
    wr(OFS_CFG_B, 32'h0093);
    wr(OFS_HOST_TEMP, 32'h3333);
    repeat (2) @(posedge pclk);
    chk("temp", 32'h3333, temperature);
    @(posedge pclk) battery_removed <= 1;
    @(posedge pclk) battery_removed <= 0;
    rd(OFS_STATUS, 32'h0, "status");
    chk("irq act", 1, irq_act);
    wr(OFS_CMD, 32'h1);
    rd(OFS_STATUS, 32'h4, "status");
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CFG_A, 32'h0132 | (m << 11));
      repeat (2) @(posedge pclk);
      chk("pin mode", m, pin_mode);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_DEBUG, m);
      repeat (2) @(posedge pclk);
      chk("delta mode", m, delta_mode);
    end
    wr(OFS_WR_WAIT, 32'h2);
    @(posedge pclk) flash_write_req <= 1;
    @(posedge pclk) flash_write_req <= 0;
    repeat (2) @(posedge pclk);
    chk("write ind", 1, irq_act);
    k = 0;
    while (flash_write_go !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    chk("write delay", 1, k < 20 && k + 2 >= 2 * 2);
    results();
  end
endmodule
